// *** hw/adco_top.v ***
// audio input control register with serial audio receiver and filter path
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "adco_regs.vh"

// What this block does
// - filter skip bit zero filters audio, one routes audio around the filter
// - the enabled filter removes dc so dc protection is not tripped
// - slot source zero takes channel from address pins, one from slot select
// - speed bit picks single speed when zero, double speed when one
// - format codes zero to three are right justified 24, 20, 18, 16 bits
// - code four is standard i2s and reset value, five left justified
// - slot select field names the tdm channel when slot source is set
module adco_top
(
   // clock and reset
   input wire clock,
   input wire rst_n,
   // avalon-mm register slave
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output wire avs_waitrequest,
   output reg [31:0] avs_readdata,
   // device address straps and serial audio pins
   input wire [2:0] bus_addr_pins,
   input wire sclk_pin,
   input wire lrclk_pin,
   input wire sdata_pin,
   // playback sample stream
   output wire play_valid,
   output wire [23:0] play_sample,
   // settings seen by the rest of the audio path
   output wire rate_speed_sel,
   output wire [2:0] input_format_sel,
   output wire [2:0] play_slot
);

   // word width of a format; short right-justified words end the slot
   function [5:0] fmt_width;
      input [2:0] fmt;
      begin
         case (fmt)
            `ADCO_FMT_RJ20: fmt_width = `ADCO_W20;
            `ADCO_FMT_RJ18: fmt_width = `ADCO_W18;
            `ADCO_FMT_RJ16: fmt_width = `ADCO_W16;
            default: fmt_width = `ADCO_W24;
         endcase
      end
   endfunction

   // first bit position in the slot of a format
   function [5:0] fmt_first;
      input [2:0] fmt;
      begin
         case (fmt)
            `ADCO_FMT_RJ24,
            `ADCO_FMT_RJ20,
            `ADCO_FMT_RJ18,
            `ADCO_FMT_RJ16: fmt_first = `ADCO_SLOT_LEN - fmt_width(fmt);
            `ADCO_FMT_LJ: fmt_first = 6'h00;
            default: fmt_first = 6'h01;
         endcase
      end
   endfunction

   // registers
   reg [7:0] aic_q;
   reg [7:0] slot_q;
   reg ack_q;

   // synchronisers
   reg [2:0] addr_s1_q;
   reg [2:0] addr_s2_q;
   reg sclk_s1_q;
   reg sclk_s2_q;
   reg sclk_s3_q;
   reg lr_s1_q;
   reg lr_s2_q;
   reg sd_s1_q;
   reg sd_s2_q;

   // receiver state
   reg lr_prev_q;
   reg [7:0] bit_pos_q;
   reg [23:0] shift_q;
   reg raw_valid_q;
   reg [23:0] raw_sample_q;
   reg [7:0] bit_pos_d;
   reg [23:0] shift_d;

   // control decode
   wire filter_skip_bit;
   wire slot_source_sel;
   wire [2:0] slot_select;
   wire is_i2s;
   wire [5:0] word_w;
   wire [5:0] first_pos;
   wire [4:0] pole_shift;
   wire req;
   wire take;
   wire sclk_rise;
   wire frame_start;
   wire [5:0] slot_pos;
   wire [2:0] slot_idx;
   wire in_win;
   wire slot_end;
   wire [7:0] status;

   assign filter_skip_bit = aic_q[`ADCO_BIT_SKIP];
   assign slot_source_sel = aic_q[`ADCO_BIT_SRC];
   assign rate_speed_sel = aic_q[`ADCO_BIT_SPEED];
   assign input_format_sel = aic_q[`ADCO_FMT_HI:`ADCO_FMT_LO];
   assign slot_select = slot_q[`ADCO_SLOT_HI:`ADCO_SLOT_LO];

   // playback channel source
   assign play_slot = slot_source_sel ? slot_select : addr_s2_q;

   // reserved codes six and seven fall back to i2s framing;
   // code four does too; every code other than four, six and seven frames on the rising lrclk edge
   assign is_i2s = (input_format_sel[2:1] == 2'b11) ||
                   (input_format_sel == `ADCO_FMT_I2S);
   assign word_w = fmt_width(input_format_sel);
   assign first_pos = fmt_first(input_format_sel);

   // filter pole follows the sample rate so the corner stays put
   assign pole_shift = rate_speed_sel ? `ADCO_HPF_K_DS : `ADCO_HPF_K_SS;

   // bus handshake: one wait cycle, then the answer
   // waitrequest is combinational so the wait shows in the request's
   // own cycle; ack drops after the taken edge, so a back-to-back
   // request gets its wait cycle again
   assign req = avs_read | avs_write;
   assign take = req & ack_q;
   assign avs_waitrequest = req & ~ack_q;

   // status: active slot, filter in use, speed, format reserved flag
   // status is read only; writes to its index are dropped
   assign status = {2'h0, (input_format_sel[2:1] == 2'b11), rate_speed_sel,
                    ~filter_skip_bit, play_slot};

   // register writes and the handshake flag
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         aic_q <= `ADCO_RST_AIC;
         slot_q <= `ADCO_RST_SLOT;
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= req & ~ack_q;
         if (take && avs_write && avs_byteenable[0])
         begin
            if (avs_address == {`ADCO_IDX_AIC, 2'b00})
               aic_q <= avs_writedata[7:0];
            else if (avs_address == {`ADCO_IDX_SLOT, 2'b00})
               slot_q <= avs_writedata[7:0];
         end
      end
   end

   // read data are captured in the wait cycle, unmapped reads give zero
   // capturing early lets readdata come from a flop and still stand at
   // the edge where waitrequest is low
   always @(posedge clock)
   begin
      if (!rst_n)
         avs_readdata <= 32'h00000000;
      else if (req && !ack_q && avs_read)
      begin
         if (avs_address == {`ADCO_IDX_AIC, 2'b00})
            avs_readdata <= {24'h000000, aic_q};
         else if (avs_address == {`ADCO_IDX_SLOT, 2'b00})
            avs_readdata <= {24'h000000, slot_q};
         else if (avs_address == {`ADCO_IDX_STAT, 2'b00})
            avs_readdata <= {24'h000000, status};
         else
            avs_readdata <= 32'h00000000;
      end
   end

   // two-stage synchronisers for the pins, third stage for edges
   // sclk must run no faster than half of clock or rises are missed
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         addr_s1_q <= 3'h0;
         addr_s2_q <= 3'h0;
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_s3_q <= 1'b0;
         lr_s1_q <= 1'b0;
         lr_s2_q <= 1'b0;
         sd_s1_q <= 1'b0;
         sd_s2_q <= 1'b0;
      end
      else
      begin
         addr_s1_q <= bus_addr_pins;
         addr_s2_q <= addr_s1_q;
         sclk_s1_q <= sclk_pin;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         lr_s1_q <= lrclk_pin;
         lr_s2_q <= lr_s1_q;
         sd_s1_q <= sdata_pin;
         sd_s2_q <= sd_s1_q;
      end
   end

   // frame starts on the lrclk edge that opens the first channel
   // lrclk is looked at only on sclk rises, so a glitch between rises
   // is ignored; the bit counter wraps every 256 rises on its own
   assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
   assign frame_start = (lr_s2_q != lr_prev_q) && (lr_s2_q == ~is_i2s);

   // bit position within the frame at this sclk rise
   always @*
   begin
      bit_pos_d = bit_pos_q;
      if (frame_start)
         bit_pos_d = 8'h00;
      else
         bit_pos_d = bit_pos_q + 8'h01;
   end

   assign slot_pos = {1'b0, bit_pos_d[4:0]};
   assign slot_idx = bit_pos_d[7:5];
   assign in_win = (slot_idx == play_slot) && (slot_pos >= first_pos) &&
                   (slot_pos < first_pos + word_w);
   assign slot_end = (slot_idx == play_slot) &&
                     (slot_pos == `ADCO_SLOT_LEN - 6'h01);

   // shift register next value, msb first
   // a frame start clears the word so a cut frame leaves no stale bits
   always @*
   begin
      shift_d = frame_start ? 24'h000000 : shift_q;
      if (in_win)
         shift_d = {shift_d[22:0], sd_s2_q};
   end

   // serial receiver: shift the chosen slot and emit at its end
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         lr_prev_q <= 1'b0;
         bit_pos_q <= 8'h00;
         shift_q <= 24'h000000;
         raw_valid_q <= 1'b0;
         raw_sample_q <= 24'h000000;
      end
      else
      begin
         raw_valid_q <= 1'b0;
         if (sclk_rise)
         begin
            lr_prev_q <= lr_s2_q;
            bit_pos_q <= bit_pos_d;
            if (slot_end)
            begin
               // left-align short words to the full sample width
               raw_sample_q <= shift_d << (`ADCO_W24 - word_w);
               raw_valid_q <= 1'b1;
               shift_q <= 24'h000000;
            end
            else
               shift_q <= shift_d;
         end
      end
   end

   // dc-removing filter or bypass
   // filter state keeps running in bypass, so enabling it mid-stream
   // starts from the true sample history
   adco_hpf u_hpf
   (
      .clock(clock),
      .rst_n(rst_n),
      .bypass(filter_skip_bit),
      .pole_shift(pole_shift),
      .in_valid(raw_valid_q),
      .in_sample(raw_sample_q),
      .out_valid(play_valid),
      .out_sample(play_sample)
   );

endmodule // adco_top

`default_nettype wire

// *** hw/adco_regs.vh ***
// register offsets, field positions, reset values and codes of the audio input control block
`ifndef ADCO_REGS_VH
`define ADCO_REGS_VH

// register indices; the byte address is four times the index
`define ADCO_IDX_AIC 6'h02
`define ADCO_IDX_SLOT 6'h03
`define ADCO_IDX_STAT 6'h20

// reset values
`define ADCO_RST_AIC 8'h04
`define ADCO_RST_SLOT 8'h80

// field positions in audio_input_control
`define ADCO_BIT_SKIP 7
`define ADCO_BIT_SRC 6
`define ADCO_BIT_RSV_HI 5
`define ADCO_BIT_RSV_LO 4
`define ADCO_BIT_SPEED 3
`define ADCO_FMT_HI 2
`define ADCO_FMT_LO 0

// field position of the slot select in the slot control register
`define ADCO_SLOT_HI 2
`define ADCO_SLOT_LO 0

// serial audio word format codes
`define ADCO_FMT_RJ24 3'h0
`define ADCO_FMT_RJ20 3'h1
`define ADCO_FMT_RJ18 3'h2
`define ADCO_FMT_RJ16 3'h3
`define ADCO_FMT_I2S 3'h4
`define ADCO_FMT_LJ 3'h5

// word widths in bits and slot length
`define ADCO_W24 6'h18
`define ADCO_W20 6'h14
`define ADCO_W18 6'h12
`define ADCO_W16 6'h10
`define ADCO_SLOT_LEN 6'h20

// high-pass pole shift for single and double speed
`define ADCO_HPF_K_SS 5'h0A
`define ADCO_HPF_K_DS 5'h0B

`endif

// *** hw/adco_hpf.v ***
// first order dc-removing high-pass filter with bypass
`timescale 1ns/1ps
`default_nettype none

module adco_hpf
(
   // clock and reset
   input wire clock,
   input wire rst_n,
   // control
   input wire bypass,
   input wire [4:0] pole_shift,
   // sample in
   input wire in_valid,
   input wire [23:0] in_sample,
   // sample out
   output reg out_valid,
   output reg [23:0] out_sample
);

   reg signed [27:0] x_prev_q;
   reg signed [27:0] y_prev_q;
   wire signed [27:0] x_ext;
   wire signed [27:0] y_new;
   wire signed [23:0] y_sat;

   // y = x - x_prev + y_prev - y_prev * 2^-k, a pole just below one
   assign x_ext = {{4{in_sample[23]}}, in_sample};
   assign y_new = x_ext - x_prev_q + y_prev_q - (y_prev_q >>> pole_shift);

   // saturate back to the sample width
   assign y_sat = (y_new > 28'sh07FFFFF) ? 24'sh7FFFFF :
                  (y_new < -28'sh0800000) ? 24'sh800000 : y_new[23:0];

   // filter state moves only on a new sample
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         x_prev_q <= 28'h0000000;
         y_prev_q <= 28'h0000000;
         out_valid <= 1'b0;
         out_sample <= 24'h000000;
      end
      else
      begin
         out_valid <= in_valid;
         if (in_valid)
         begin
            x_prev_q <= x_ext;
            y_prev_q <= y_new;
            if (bypass)
               out_sample <= in_sample;
            else
               out_sample <= y_sat;
         end
      end
   end

endmodule // adco_hpf

`default_nettype wire

// *** testbench/adco_top_props.sv ***
// checker for the audio input control register ports
`timescale 1ns/1ps
`default_nettype none
`include "adco_regs.vh"
module adco_chk
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // register bus
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   // audio side
   input wire logic play_valid,
   input wire logic [23:0] play_sample,
   input wire logic rate_speed_sel,
   input wire logic [2:0] input_format_sel,
   input wire logic [2:0] play_slot
);
   logic [7:0] aic_q;
   logic [7:0] slot_q;
   wire rq = avs_read | avs_write;
   wire rd = avs_read & ~avs_waitrequest;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // shadow copy of the two writable registers
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         aic_q <= `ADCO_RST_AIC;
         slot_q <= `ADCO_RST_SLOT;
      end
      else if (avs_write & ~avs_waitrequest & avs_byteenable[0])
      begin
         if (avs_address == 8'h08) aic_q <= avs_writedata[7:0];
         if (avs_address == 8'h0C) slot_q <= avs_writedata[7:0];
      end
   end
   wait_first_a: assert property (rq && !$past(rq) |-> avs_waitrequest)
      else $error("no wait cycle");
   wait_once_a: assert property (rq && avs_waitrequest |=> !avs_waitrequest)
      else $error("wait too long");
   aic_read_a: assert property (rd && avs_address == 8'h08 |->
      avs_readdata == {24'h000000, aic_q})
      else $error("control readback");
   slot_read_a: assert property (rd && avs_address == 8'h0C |->
      avs_readdata == {24'h000000, slot_q})
      else $error("slot readback");
   hole_read_a: assert property (rd && avs_address == 8'h40 |->
      avs_readdata == 32'h00000000)
      else $error("unmapped read");
   speed_out_a: assert property (rate_speed_sel == aic_q[3])
      else $error("speed output");
   format_out_a: assert property (input_format_sel == aic_q[2:0])
      else $error("format output");
   slot_route_a: assert property (aic_q[6] |-> play_slot == slot_q[2:0])
      else $error("slot routing");
   valid_pulse_a: assert property (play_valid |=> !play_valid)
      else $error("valid too long");
   hold_smp_a: assert property (!play_valid |-> $stable(play_sample))
      else $error("sample moved");
   // main scenarios reached
   c_rd: cover property (rd && avs_address == 8'h08);
   c_val: cover property (play_valid);
   c_src: cover property (aic_q[6] && play_valid);
endmodule // adco_chk
bind adco_top adco_chk u_chk (.clock(clock), .rst_n(rst_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
   .play_valid(play_valid), .play_sample(play_sample),
   .rate_speed_sel(rate_speed_sel), .input_format_sel(input_format_sel),
   .play_slot(play_slot));
`default_nettype wire

// *** testbench/adco_top_tb_top.sv ***
// self-checking bench of the audio input control block
`timescale 1ns/1ps
`default_nettype none
module adco_top_tb_top;
   logic clock = 0, rst_n = 0, rd = 0, wr = 0, sck = 0, lrck = 0, sd = 0;
   logic [7:0] adr = 0;
   logic [31:0] wd = 0, q, w [0:7];
   logic [3:0] be = 0;
   logic [2:0] pins = 0, slot_o, fmt_o;
   wire logic wt, pv, spd;
   logic [31:0] rdat;
   logic [23:0] ps, last_q;
   logic [23:0] ex;
   integer err_total = 0, checks = 0, nv = 0, f, k, s;
   integer xp = 0, yp = 0, ym;
   adco_top u_adco_top (.clock(clock), .rst_n(rst_n), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_byteenable(be), .avs_waitrequest(wt), .avs_readdata(rdat),
      .bus_addr_pins(pins), .sclk_pin(sck), .lrclk_pin(lrck),
      .sdata_pin(sd), .play_valid(pv), .play_sample(ps),
      .rate_speed_sel(spd), .input_format_sel(fmt_o), .play_slot(slot_o));
   always #5 clock = ~clock;
   // capture every sample pulse
   always @(posedge clock)
   begin
      if (pv === 1'b1)
      begin
         last_q <= ps;
         nv <= nv + 1;
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp)
      begin
         err_total = err_total + 1;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // one avalon cycle, held until waitrequest is sampled low
   task bus(input logic w_i, input logic [7:0] a_i, input logic [31:0] d_i,
      input logic [3:0] be_i);
      integer n;
      @(posedge clock);
      n = 0;
      rd <= !w_i;
      wr <= w_i;
      adr <= a_i;
      wd <= d_i;
      be <= be_i;
      @(posedge clock);
      while (wt !== 1'b0)
      begin
         n = n + 1;
         if (n == 50)
         begin
            err_total = err_total + 1;
            end_sim;
         end
         @(posedge clock);
      end
      q = rdat;
      rd <= 0;
      wr <= 0;
   endtask
   // one 8-slot frame, word per slot msb first, idle clock held low
   task frame(input logic i2s);
      integer n;
      lrck <= i2s;
      repeat (16) @(posedge clock);
      for (n = 0; n < 256; n = n + 1)
      begin
         lrck <= (n < 128) ? !i2s : i2s;
         sd <= w[n / 32][31 - n % 32];
         sck <= 0;
         repeat (4) @(posedge clock);
         sck <= 1;
         repeat (4) @(posedge clock);
      end
      sck <= 0;
      repeat (24) @(posedge clock);
   endtask
   function logic [23:0] ext(input integer fm, input logic [31:0] x);
      case (fm)
         0: ext = x[23:0];
         1: ext = {x[19:0], 4'h0};
         2: ext = {x[17:0], 6'h0};
         3: ext = {x[15:0], 8'h0};
         4: ext = x[30:7];
         default: ext = x[31:8];
      endcase
   endfunction
   // reference filter: one step per received sample, sets ex
   task model(input logic [23:0] x, input logic skip, input integer kk);
      integer xi;
      xi = $signed(x);
      ym = xi - xp + yp - (yp >>> kk);
      xp = xi;
      yp = ym;
      if (skip)
         ex = x;
      else if (ym > 32'sh007FFFFF)
         ex = 24'h7FFFFF;
      else if (ym < -32'sh00800000)
         ex = 24'h800000;
      else
         ex = ym[23:0];
   endtask
   // one frame, then the sample and the sample count against the model
   task play(input integer fm, input logic [2:0] sl, input logic skip,
      input integer kk);
      integer n0;
      n0 = nv;
      frame(fm == 4);
      model(ext(fm, w[sl]), skip, kk);
      chk(last_q, ex);
      chk(nv - n0, 1);
   endtask
   initial begin
      #400000;
      err_total = err_total + 1;
      end_sim;
   end
   initial begin
      void'($urandom(32'h164966C5));
      repeat (3) @(posedge clock);
      rst_n <= 1;
      bus(0, 8'h08, 0, 4'hF); chk(q, 32'h04);
      bus(0, 8'h0C, 0, 4'hF); chk(q, 32'h80);
      bus(0, 8'h40, 0, 4'hF); chk(q, 0);
      // host keeps reserved bits and codes six, seven out
      k = ($urandom & 8'hC8) | ($urandom % 6);
      bus(1, 8'h08, k, 4'hF);
      bus(1, 8'h08, 8'h3F, 4'hE);
      bus(1, 8'h44, 8'h3F, 4'hF);
      bus(0, 8'h08, 0, 4'hF); chk(q, k);
      chk({fmt_o, spd}, {k[2:0], k[3]});
      $display("register test done");
      for (f = 0; f < 6; f = f + 1)
      begin
         bus(1, 8'h08, 8'h80 | f, 4'hF);
         for (s = 0; s < 8; s = s + 1) w[s] = $urandom;
         s = $urandom % 8;
         pins <= s[2:0];
         play(f, s[2:0], 1'b1, 10);
         chk(slot_o, s);
      end
      $display("format test done");
      s = $urandom % 8;
      bus(1, 8'h0C, 8'h80 | s, 4'hF);
      bus(1, 8'h08, 8'hC4, 4'hF);
      play(4, s[2:0], 1'b1, 10);
      chk(slot_o, s);
      $display("slot test done");
      for (f = 0; f < 2; f = f + 1)
      begin
         bus(1, 8'h08, 8'h04 | (f << 3), 4'hF);
         k = $urandom;
         for (s = 0; s < 8; s = s + 1) w[s] = k;
         repeat (2) play(4, pins, 1'b0, 10 + f);
      end
      $display("filter test done");
      end_sim;
   end
endmodule // adco_top_tb_top
`default_nettype wire
